// ---- i2c_gc_pkg.sv ----
package i2c_gc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL1 = 8'h00;
	localparam logic [7:0] OFS_CTRL2 = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_BUF = 8'h0C;
	localparam logic [7:0] OFS_ADDR = 8'h10;
	// values after reset
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] ADDR_RST = 8'h02;
	// port_mode_select codes
	localparam logic [3:0] MODE_MASTER = 4'h8;
	localparam logic [3:0] MODE_SLV7 = 4'h6;
	localparam logic [3:0] MODE_SLV10 = 4'h7;
	// fixed addresses
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [4:0] TEN_HDR = 5'h1E;
	// aclk cycles per phase_two / phase_four tick
	localparam int PHASE_CYC = 2;
	localparam int BRG_W = 7;
	localparam logic [3:0] BITS_TX = 4'h9;
	localparam logic [3:0] BITS_RX = 4'h8;
	localparam logic [3:0] BITS_ACK = 4'h1;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_DEC = 2'h3;

	typedef struct packed {
		logic [1:0] spare;
		logic pin_direction_bits;
		logic [3:0] port_mode_select;
		logic port_enable_bit;
	} ctrl1_t;

	typedef struct packed {
		logic general_call_enable;
		logic acknowledge_status_bit;
		logic ack_data;
		logic ack_req;
		logic rx_req;
		logic stop_request_bit;
		logic rstart_req;
		logic start_request_bit;
	} ctrl2_t;

	typedef struct packed {
		logic bus_collision_flag;
		logic write_collision_flag;
		logic serial_port_irq_flag;
		logic stop_seen;
		logic start_seen;
		logic spare;
		logic update_address_flag;
		logic buffer_full_flag;
	} stat_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} pins_t;

	typedef enum {M_IDLE, M_ST_HOLD, M_ST_LOW, M_RS_LOW, M_RS_WAIT,
		M_RS_HIGH, M_RS_SDA, M_BIT_LO, M_BIT_WAIT, M_BIT_HI,
		M_SP_LOW, M_SP_WAIT, M_SP_HIGH} mst_t;

	typedef enum {K_TX, K_RX, K_ACK} kind_t;
endpackage

// ---- pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import i2c_gc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// raw pins and synchronised copy
	input wire pins_t raw,
	output pins_t synced
);
	pins_t meta_r;

	// two stages; idle bus level is high so reset to ones
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '1;
			synced <= '1;
		end else if (ce) begin
			meta_r <= raw;
			synced <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ---- baud_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module baud_counter
	import i2c_gc_pkg::*;
#(
	parameter int W = BRG_W
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// control
	input wire logic load,
	input wire logic tick,
	input wire logic [W-1:0] reload,
	// status
	output logic done
);
	logic [W-1:0] cnt_r;

	// counts down on each phase tick, then parks at zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
			done <= 1'b1;
		end else if (ce) begin
			if (load) begin
				cnt_r <= reload;
				done <= 1'b0;
			end else if (tick && cnt_r != '0) begin
				cnt_r <= cnt_r - 1'b1;
				done <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
			end
		end
	end

	property p_brg_park;
		@(posedge aclk) disable iff (!aresetn || !ce)
		(cnt_r == '0 && !load) |=> (cnt_r == '0 && done);
	endproperty
	a_brg_park: assert property (p_brg_park)
		else $error("baud counter left zero without reload");
endmodule
`default_nettype wire

// ---- i2c_gc_master.sv ----
// Contract
// - general call enable recognises all-zero address byte
// - shift eight bits, compare own and call
// - call match: buffer load, full, flag ninth
// - ten-bit general call skips update-address flag
// - enable plus mode; pins driven per direction
// - start/stop seen cleared by reset, disable
// - buffer write during operation: collision, dropped
// - flag on start, stop, restart, byte, ack
// - master makes clocks, start, stop, restart
// - write: address, zero direction bit, acks
// - read: address, one bit, master acks
// - ninth clock samples ack, sets flag
// - start and stop request bits; flag after
// - reload low seven bits; buffer write starts
// - counter down to zero, twice per cycle
// - after completion counter stops, clock held
// - bus clock period is two rollovers
// - released clock waits high, then reloads
// - start completes after one more timeout
// - lines low at start: collision, abort
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module i2c_gc_master
	import i2c_gc_pkg::*;
(
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// open-drain bus pins
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	ctrl1_t c1_r;
	ctrl2_t c2_r;
	stat_t st_r;
	logic [7:0] buf_r, adr_r, sh_r;
	mst_t m_r;
	kind_t kind_r;
	logic [3:0] bit_r;
	logic scl_drv_r, sda_drv_r, brg_load_r, brg_done, tick;
	logic [$clog2(PHASE_CYC)-1:0] ph_r;
	pins_t bus, bus_p_r;
	logic start_det, stop_det, master, wr_fire, rd_fire, bdone;
	logic sl_act_r, sl_addr_r, sl_hit_r, sl_ack_r, sl_load_r;
	logic sl_irq_r, sl_ua_r;
	logic [3:0] sl_bit_r;
	logic [7:0] sl_sh_r, sl_byte_r, nb;

	// address decode helper, shared by both bus channels
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == OFS_CTRL1) || (a == OFS_CTRL2) || (a == OFS_STAT)
			|| (a == OFS_BUF) || (a == OFS_ADDR);
	endfunction

	pin_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.raw('{scl: scl_i, sda: sda_i}),
		.synced(bus)
	);

	baud_counter #(.W(BRG_W)) u_brg (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.load(brg_load_r),
		.tick(tick),
		.reload(adr_r[BRG_W-1:0]),
		.done(brg_done)
	);

	assign master = c1_r.port_enable_bit
		&& c1_r.port_mode_select == MODE_MASTER;
	assign wr_fire = awvalid && awready && wvalid && wready;
	assign rd_fire = arvalid && arready;
	// fresh load hides the stale done of the previous phase
	assign bdone = brg_done && !brg_load_r;
	assign start_det = bus_p_r.sda && !bus.sda && bus.scl && bus_p_r.scl;
	assign stop_det = !bus_p_r.sda && bus.sda && bus.scl && bus_p_r.scl;
	assign nb = {sl_sh_r[6:0], bus.sda};
	assign tick = (ph_r == '0);

	// phase tick generator: two decrements per instruction cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph_r <= '0;
			bus_p_r <= '1;
		end else if (ce) begin
			ph_r <= (ph_r == ($clog2(PHASE_CYC))'(PHASE_CYC - 1)) ? '0
				: ph_r + 1'b1;
			bus_p_r <= bus;
		end
	end

	// axi handshakes; one write and one read in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OK;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rresp <= RESP_OK;
		end else if (ce) begin
			awready <= awvalid && wvalid && !awready && !bvalid;
			wready <= awvalid && wvalid && !awready && !bvalid;
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= mapped(awaddr) ? RESP_OK : RESP_DEC;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			arready <= arvalid && !arready && !rvalid;
			if (rd_fire) begin
				rvalid <= 1'b1;
				rresp <= mapped(araddr) ? RESP_OK : RESP_DEC;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// read data mux; buffer read returns the last byte loaded into buf_r
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= 32'h0000_0000;
		end else if (ce && rd_fire) begin
			case (araddr)
				OFS_CTRL1: rdata <= {24'h000000, c1_r};
				OFS_CTRL2: rdata <= {24'h000000, c2_r};
				OFS_STAT: rdata <= {24'h000000, st_r};
				OFS_BUF: rdata <= {24'h000000, buf_r};
				OFS_ADDR: rdata <= {24'h000000, adr_r};
				default: rdata <= 32'h0000_0000;
			endcase
		end
	end

	// slave address recogniser, only when not master
	always_ff @(posedge aclk) begin
		if (!aresetn || !c1_r.port_enable_bit || master) begin
			sl_act_r <= 1'b0;
			sl_addr_r <= 1'b0;
			sl_hit_r <= 1'b0;
			sl_ack_r <= 1'b0;
			sl_bit_r <= '0;
			sl_sh_r <= '0;
			sl_load_r <= 1'b0;
			sl_irq_r <= 1'b0;
			sl_ua_r <= 1'b0;
			sl_byte_r <= '0;
		end else if (ce) begin
			sl_load_r <= 1'b0;
			sl_irq_r <= 1'b0;
			sl_ua_r <= 1'b0;
			if (start_det) begin
				sl_act_r <= 1'b1;
				sl_addr_r <= 1'b1;
				sl_hit_r <= 1'b0;
				sl_bit_r <= '0;
			end else if (stop_det) begin
				sl_act_r <= 1'b0;
				sl_ack_r <= 1'b0;
			end else if (sl_act_r && bus.scl && !bus_p_r.scl) begin
				sl_bit_r <= sl_bit_r + 1'b1;
				if (sl_bit_r < BITS_RX) begin
					sl_sh_r <= nb;
				end
				if (sl_bit_r == BITS_RX - 1'b1) begin
					if (!sl_addr_r
						|| (c2_r.general_call_enable && nb == GC_ADDR)
						|| (c1_r.port_mode_select == MODE_SLV7
						&& nb[7:1] == adr_r[7:1])) begin
						sl_hit_r <= 1'b1;
						sl_load_r <= 1'b1;
						sl_byte_r <= nb;
					end else if (c1_r.port_mode_select == MODE_SLV10
						&& nb[7:3] == TEN_HDR && nb[2:1] == adr_r[2:1]) begin
						sl_hit_r <= 1'b1;
						sl_ua_r <= 1'b1;
						sl_byte_r <= nb;
						sl_load_r <= 1'b1;
					end else begin
						sl_act_r <= 1'b0;
					end
				end
			end else if (sl_act_r && !bus.scl && bus_p_r.scl) begin
				// ack driven over the ninth clock, flag at its fall
				if (sl_bit_r == BITS_RX && sl_hit_r) begin
					sl_ack_r <= 1'b1;
				end else if (sl_bit_r == BITS_TX) begin
					sl_ack_r <= 1'b0;
					sl_irq_r <= sl_hit_r;
					sl_addr_r <= 1'b0;
					sl_bit_r <= '0;
				end
			end
		end
	end

	// master engine, control and status flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c1_r <= CTRL1_RST;
			c2_r <= CTRL2_RST;
			st_r <= STAT_RST;
			adr_r <= ADDR_RST;
			buf_r <= '0;
			sh_r <= '0;
			m_r <= M_IDLE;
			kind_r <= K_TX;
			bit_r <= '0;
			scl_drv_r <= 1'b0;
			sda_drv_r <= 1'b0;
			brg_load_r <= 1'b0;
		end else if (ce) begin
			brg_load_r <= 1'b0;
			// software access; sticky flags cleared by writing one
			if (wr_fire && wstrb[0]) begin
				case (awaddr)
					OFS_CTRL1: c1_r <= wdata[7:0];
					OFS_CTRL2: begin
						c2_r.general_call_enable <= wdata[7];
						c2_r.ack_data <= wdata[5];
						if (m_r == M_IDLE) begin
							c2_r.ack_req <= wdata[4];
							c2_r.rx_req <= wdata[3];
							c2_r.stop_request_bit <= wdata[2];
							c2_r.rstart_req <= wdata[1];
							c2_r.start_request_bit <= wdata[0];
						end
					end
					OFS_STAT: st_r <= st_r & ~(wdata[7:0] & 8'hE0);
					OFS_BUF: begin
						if (master && (m_r != M_IDLE || c2_r[3:0] != '0))
						begin
							st_r.write_collision_flag <= 1'b1;
						end else begin
							buf_r <= wdata[7:0];
							if (master) begin
								sh_r <= wdata[7:0];
								st_r.buffer_full_flag <= 1'b1;
								kind_r <= K_TX;
								bit_r <= '0;
								m_r <= M_BIT_LO;
								scl_drv_r <= 1'b1;
								brg_load_r <= 1'b1;
							end
						end
					end
					OFS_ADDR: begin
						adr_r <= wdata[7:0];
						st_r.update_address_flag <= 1'b0;
					end
					default: ;
				endcase
			end
			if (rd_fire && araddr == OFS_BUF) begin
				st_r.buffer_full_flag <= 1'b0;
			end
			// slave-side events
			if (sl_load_r) begin
				buf_r <= sl_byte_r;
				st_r.buffer_full_flag <= 1'b1;
			end
			if (sl_ua_r) begin
				st_r.update_address_flag <= 1'b1;
			end
			if (sl_irq_r) begin
				st_r.serial_port_irq_flag <= 1'b1;
			end
			// bus monitor: start and stop seen
			if (!c1_r.port_enable_bit) begin
				st_r.start_seen <= 1'b0;
				st_r.stop_seen <= 1'b0;
			end else if (start_det) begin
				st_r.start_seen <= 1'b1;
				st_r.stop_seen <= 1'b0;
			end else if (stop_det) begin
				st_r.stop_seen <= 1'b1;
				st_r.start_seen <= 1'b0;
			end
			if (!master) begin
				m_r <= M_IDLE;
				scl_drv_r <= 1'b0;
				sda_drv_r <= 1'b0;
			end else begin
				case (m_r)
					M_IDLE: begin
						// held levels stay; counter parked
						if (c2_r.start_request_bit) begin
							if (!bus.scl || !bus.sda) begin
								st_r.bus_collision_flag <= 1'b1;
								c2_r.start_request_bit <= 1'b0;
							end else begin
								m_r <= M_ST_HOLD;
								brg_load_r <= 1'b1;
							end
						end else if (c2_r.rstart_req) begin
							m_r <= M_RS_LOW;
							scl_drv_r <= 1'b1;
							sda_drv_r <= 1'b0;
							brg_load_r <= 1'b1;
						end else if (c2_r.stop_request_bit) begin
							m_r <= M_SP_LOW;
							scl_drv_r <= 1'b1;
							sda_drv_r <= 1'b1;
							brg_load_r <= 1'b1;
						end else if (c2_r.rx_req || c2_r.ack_req) begin
							kind_r <= c2_r.rx_req ? K_RX : K_ACK;
							bit_r <= '0;
							m_r <= M_BIT_LO;
							scl_drv_r <= 1'b1;
							sda_drv_r <= !c2_r.rx_req && !c2_r.ack_data;
							brg_load_r <= 1'b1;
						end
					end
					M_ST_HOLD: begin
						if (!bus.scl || !bus.sda) begin
							st_r.bus_collision_flag <= 1'b1;
							c2_r.start_request_bit <= 1'b0;
							m_r <= M_IDLE;
						end else if (bdone) begin
							sda_drv_r <= 1'b1;
							brg_load_r <= 1'b1;
							m_r <= M_ST_LOW;
						end
					end
					M_ST_LOW: begin
						if (bdone) begin
							c2_r.start_request_bit <= 1'b0;
							st_r.serial_port_irq_flag <= 1'b1;
							m_r <= M_IDLE;
						end
					end
					M_RS_LOW: begin
						if (bdone && bus.sda) begin
							scl_drv_r <= 1'b0;
							m_r <= M_RS_WAIT;
						end
					end
					M_RS_WAIT: begin
						if (bus.scl) begin
							brg_load_r <= 1'b1;
							m_r <= M_RS_HIGH;
						end
					end
					M_RS_HIGH: begin
						if (!bus.sda || !bus.scl) begin
							st_r.bus_collision_flag <= 1'b1;
							c2_r.rstart_req <= 1'b0;
							m_r <= M_IDLE;
						end else if (bdone) begin
							sda_drv_r <= 1'b1;
							brg_load_r <= 1'b1;
							m_r <= M_RS_SDA;
						end
					end
					M_RS_SDA: begin
						if (bdone) begin
							c2_r.rstart_req <= 1'b0;
							st_r.serial_port_irq_flag <= 1'b1;
							m_r <= M_IDLE;
						end
					end
					M_BIT_LO: begin
						// data moves a cycle after the clock is driven low,
						// so no slave sees a false start or stop
						if (kind_r == K_TX) begin
							sda_drv_r <= (bit_r < BITS_RX)
								&& !sh_r[~bit_r[2:0]];
						end
						if (bdone) begin
							scl_drv_r <= 1'b0;
							m_r <= M_BIT_WAIT;
						end
					end
					M_BIT_WAIT: begin
						// a slave may stretch; the high phase waits for it
						if (bus.scl) begin
							brg_load_r <= 1'b1;
							m_r <= M_BIT_HI;
						end
					end
					M_BIT_HI: begin
						if (bdone) begin
							scl_drv_r <= 1'b1;
							bit_r <= bit_r + 1'b1;
							if (kind_r == K_RX) begin
								sh_r <= {sh_r[6:0], bus.sda};
							end
							if (kind_r == K_TX && bit_r == BITS_TX - 1'b1) begin
								c2_r.acknowledge_status_bit <= bus.sda;
							end
							if ((kind_r == K_TX && bit_r == BITS_TX - 1'b1)
								|| (kind_r == K_RX && bit_r == BITS_RX - 1'b1)
								|| kind_r == K_ACK) begin
								// done: clock stays low, counter stops
								m_r <= M_IDLE;
								st_r.serial_port_irq_flag <= 1'b1;
								sda_drv_r <= 1'b0;
								if (kind_r == K_RX) begin
									buf_r <= {sh_r[6:0], bus.sda};
									st_r.buffer_full_flag <= 1'b1;
									c2_r.rx_req <= 1'b0;
								end
								if (kind_r == K_ACK) begin
									c2_r.ack_req <= 1'b0;
								end
							end else begin
								brg_load_r <= 1'b1;
								m_r <= M_BIT_LO;
								if (kind_r == K_TX && bit_r == BITS_RX - 1'b1) begin
									st_r.buffer_full_flag <= 1'b0;
								end
							end
						end
					end
					M_SP_LOW: begin
						if (bdone) begin
							scl_drv_r <= 1'b0;
							m_r <= M_SP_WAIT;
						end
					end
					M_SP_WAIT: begin
						if (bus.scl) begin
							brg_load_r <= 1'b1;
							m_r <= M_SP_HIGH;
						end
					end
					M_SP_HIGH: begin
						if (bdone) begin
							sda_drv_r <= 1'b0;
							c2_r.stop_request_bit <= 1'b0;
							st_r.serial_port_irq_flag <= 1'b1;
							m_r <= M_IDLE;
						end
					end
					default: m_r <= M_IDLE;
				endcase
			end
			// hardware set wins over a software clear
			if (st_r.write_collision_flag && !(wr_fire && awaddr == OFS_BUF)
				&& wr_fire && awaddr == OFS_STAT && wdata[6]) begin
				st_r.write_collision_flag <= 1'b0;
			end
		end
	end

	// pins: open drain, driven only with direction bits set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else if (ce) begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe <= c1_r.pin_direction_bits && master && scl_drv_r;
			sda_oe <= c1_r.pin_direction_bits
				&& (master ? sda_drv_r : sl_ack_r);
		end
	end

	sequence s_busy_write;
		wr_fire && wstrb[0] && awaddr == OFS_BUF && master && m_r != M_IDLE;
	endsequence
	property p_write_collision_flag;
		@(posedge aclk) disable iff (!aresetn || !ce)
		s_busy_write |=> st_r.write_collision_flag && buf_r == $past(buf_r);
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag)
		else $error("buffer write during operation not refused");
	property p_off;
		@(posedge aclk) disable iff (!aresetn || !ce)
		!c1_r.port_enable_bit |=> !st_r.start_seen && !st_r.stop_seen;
	endproperty
	a_off: assert property (p_off)
		else $error("start or stop seen kept while disabled");
	property p_gc;
		@(posedge aclk) disable iff (!aresetn || !ce)
		sl_load_r && sl_byte_r == GC_ADDR && sl_addr_r
		|=> buf_r == GC_ADDR && st_r.buffer_full_flag;
	endproperty
	a_gc: assert property (p_gc)
		else $error("general call byte not loaded into buffer");
	property p_no_gc;
		@(posedge aclk) disable iff (!aresetn || !ce)
		sl_act_r && sl_addr_r && !master && bus.scl && !bus_p_r.scl
		&& sl_bit_r == 4'h7 && nb == GC_ADDR
		&& !c2_r.general_call_enable && adr_r[7:1] != 7'h00
		|=> !sl_load_r;
	endproperty
	a_no_gc: assert property (p_no_gc)
		else $error("zero address taken with general call off");
	property p_gc_ua;
		@(posedge aclk) disable iff (!aresetn || !ce)
		sl_load_r && sl_byte_r == GC_ADDR |-> !sl_ua_r;
	endproperty
	a_gc_ua: assert property (p_gc_ua)
		else $error("update-address raised on general call");
	property p_arb;
		@(posedge aclk) disable iff (!aresetn || !ce)
		m_r == M_BIT_WAIT && !bus.scl && master
		|=> m_r == M_BIT_WAIT && !brg_load_r;
	endproperty
	a_arb: assert property (p_arb)
		else $error("high phase began before clock seen high");
	property p_ack;
		@(posedge aclk) disable iff (!aresetn || !ce)
		m_r == M_BIT_HI && bdone && kind_r == K_TX && bit_r == 4'h8 && master
		|=> c2_r.acknowledge_status_bit == $past(bus.sda)
		&& st_r.serial_port_irq_flag && m_r == M_IDLE;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack not sampled at end of ninth clock");
	property p_dir;
		@(posedge aclk) disable iff (!aresetn || !ce)
		!c1_r.pin_direction_bits |=> !scl_oe && !sda_oe;
	endproperty
	a_dir: assert property (p_dir)
		else $error("pin driven with direction bits clear");
	property p_start_end;
		@(posedge aclk) disable iff (!aresetn || !ce)
		m_r == M_ST_LOW && bdone && master
		|=> !c2_r.start_request_bit && st_r.serial_port_irq_flag ##1 sda_oe
		|| !c1_r.pin_direction_bits;
	endproperty
	a_start_end: assert property (p_start_end)
		else $error("start not completed after second timeout");
endmodule
`default_nettype wire

// ---- i2c_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_peer #(
	parameter logic [6:0] ME = 7'h3A
) (
	// wire levels as seen on the bus
	input wire logic scl,
	input wire logic sda,
	// pull-down request and last byte taken
	output logic sda_low,
	output logic [7:0] last
);
	int n;
	logic first;
	logic sel;
	logic [7:0] sh;
	initial begin
		n = 0;
		first = 0;
		sel = 0;
		sh = 8'h00;
		sda_low = 0;
		last = 8'h00;
	end
	// start or repeated start restarts the framing
	always @(negedge sda) begin
		if (scl) begin
			n = 0;
			first = 1;
		end
	end
	// data sampled on the rising clock, msb first
	always @(posedge scl) begin
		if (n < 8)
			sh = {sh[6:0], sda};
		n = n + 1;
	end
	// only the first byte decides; later bytes acked if addressed
	always @(negedge scl) begin
		if (n == 8) begin
			if (first)
				sel = (sh[7:1] == ME) && !sh[0];
			first = 0;
			last = sh;
			sda_low = sel;
		end else if (n == 9) begin
			sda_low = 0;
			n = 0;
		end
	end
endmodule
`default_nettype wire

// ---- tb_i2c_gc_master.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", nm, e, s); end end
module tb_i2c_gc_master;
	import i2c_gc_pkg::*;
	logic aclk = 0, aresetn = 0, ce = 1;
	logic [7:0] awaddr = 0, araddr = 0, d, b;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, ack;
	logic [1:0] bresp, rresp, r;
	logic scl_o, scl_oe, sda_o, sda_oe, p_low, tsl = 0, tdl = 0;
	logic [7:0] p_last;
	int failures = 0, n_tests = 0, seed = 60;
	logic [7:0] ofs [5] = '{OFS_CTRL1, OFS_CTRL2, OFS_STAT, OFS_ADDR, OFS_BUF};
	logic [7:0] rst [5] = '{CTRL1_RST, CTRL2_RST, STAT_RST, ADDR_RST, 8'h00};
	// open-drain wires, pulled up when nobody pulls low
	wire scl_w = !(scl_oe | tsl);
	wire sda_w = !(sda_oe | tdl | p_low);
	always #2.5 aclk = !aclk;
	i2c_gc_master dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
	i2c_peer #(.ME(7'h3A)) peer_u (.scl(scl_w), .sda(sda_w),
		.sda_low(p_low), .last(p_last));
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask
	// each valid released only at the edge its ready is seen
	task automatic wr(input logic [7:0] a, input logic [7:0] v,
		output logic [1:0] s);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 0;
			if (wready === 1'b1)
				wvalid <= 0;
		end while (bvalid !== 1'b1);
		s = bresp;
		bready <= 0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v,
		output logic [1:0] s);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 0;
		end while (rvalid !== 1'b1);
		v = rdata[7:0];
		s = rresp;
		rready <= 0;
		@(posedge aclk);
	endtask
	// poll for the flag, leave status in d, then clear the flags
	task automatic wirq;
		int i;
		i = 0;
		d = 0;
		while (d[5] !== 1'b1 && i < 400) begin
			rd(OFS_STAT, d, r);
			i++;
		end
		`CHK("irq", 1'b1, d[5])
		wr(OFS_STAT, 8'hE0, r);
	endtask
	// bit-banged byte plus ninth clock, 160 ns bus period
	task automatic bb(input logic [7:0] v, output logic a);
		for (int i = 9; i > 0; i--) begin
			// data moves only once the clock has been low a while
			cyc(4);
			tdl <= (i > 1) ? !v[i-2] : 1'b0;
			cyc(12);
			tsl <= 0;
			cyc(8);
			a = sda_w;
			cyc(8);
			tsl <= 1;
		end
		cyc(16);
	endtask
	task automatic summarize;
		$display("tests %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		foreach (ofs[i]) begin
			rd(ofs[i], d, r);
			`CHK("reset value", rst[i], d)
		end
		rd(8'h14, d, r);
		`CHK("unmapped rd", RESP_DEC, r)
		wr(8'h14, 8'hFF, r);
		`CHK("unmapped wr", RESP_DEC, r)
		$display("test registers done");
		// master: nonzero reload, pins enabled, bus idle
		wr(OFS_ADDR, 8'h04, r);
		wr(OFS_CTRL1, {2'b0, 1'b1, MODE_MASTER, 1'b1}, r);
		wr(OFS_CTRL2, 8'h01, r);
		wr(OFS_BUF, 8'h55, r);
		rd(OFS_STAT, d, r);
		`CHK("write_collision_flag", 1'b1, d[6])
		wirq;
		`CHK("start seen", 1'b1, d[3])
		rd(OFS_CTRL2, d, r);
		`CHK("start bit", 1'b0, d[0])
		`CHK("sda held", 1'b0, sda_w)
		`CHK("pin levels", 2'b00, {scl_o, sda_o})
		rd(OFS_BUF, d, r);
		`CHK("buf kept", 8'h00, d)
		for (int i = 0; i < 4; i++) begin
			b = (i == 0) ? {7'h3A, 1'b0} : 8'($random(seed));
			wr(OFS_BUF, b, r);
			wirq;
			`CHK("peer byte", b, p_last)
			rd(OFS_CTRL2, d, r);
			`CHK("ack status", 1'b0, d[6])
		end
		// repeated start to an absent address
		wr(OFS_CTRL2, 8'h02, r);
		wirq;
		wr(OFS_BUF, {7'h3B, 1'b0}, r);
		wirq;
		rd(OFS_CTRL2, d, r);
		`CHK("nack status", 1'b1, d[6])
		// one byte in from a silent bus, then a refusing ack
		wr(OFS_CTRL2, 8'h08, r);
		wirq;
		`CHK("rx full", 1'b1, d[0])
		rd(OFS_BUF, d, r);
		`CHK("rx byte", 8'hFF, d)
		`CHK("rx clocks", 8'hFF, p_last)
		wr(OFS_CTRL2, 8'h30, r);
		wirq;
		wr(OFS_CTRL2, 8'h04, r);
		wirq;
		// the monitor sees the stop a few cycles after the flag
		rd(OFS_STAT, d, r);
		`CHK("stop seen", 1'b1, d[4])
		wr(OFS_CTRL1, 8'h00, r);
		rd(OFS_STAT, d, r);
		`CHK("seen cleared", 2'b00, d[4:3])
		$display("test master done");
		// ten-bit slave with general call, then seven-bit without
		wr(OFS_ADDR, 8'hA0, r);
		for (int g = 1; g >= 0; g--) begin
			wr(OFS_CTRL2, {g[0], 7'h00}, r);
			wr(OFS_CTRL1, {2'b0, 1'b1, g[0] ? MODE_SLV10 : MODE_SLV7,
				1'b1}, r);
			tdl <= 1;
			cyc(16);
			tsl <= 1;
			cyc(16);
			bb(8'h00, ack);
			`CHK("call ack", ~g[0], ack)
			rd(OFS_STAT, d, r);
			`CHK("buffer full", g[0], d[0])
			`CHK("call irq", g[0], d[5])
			`CHK("update addr", 1'b0, d[1])
			rd(OFS_BUF, d, r);
			`CHK("call byte", GC_ADDR, d)
			tdl <= 1;
			cyc(16);
			tsl <= 0;
			cyc(16);
			tdl <= 0;
			cyc(16);
			wr(OFS_STAT, 8'hE0, r);
		end
		$display("test slave done");
		summarize;
	end
	initial begin
		#400000;
		failures++;
		summarize;
	end
endmodule
`default_nettype wire
